// *** rtl/hvp_pkg.sv ***
// package: constants and state layout for high-voltage pin protection
package hvp_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned LIN_SHORT_US   = 20;
  localparam int unsigned AUX_SHORT_US   = 20;
  localparam int unsigned WAKE_SHORT_US  = 400;
  localparam int unsigned WAKE_TO_MS     = 1300;
  localparam int unsigned LIN_SHORT_CYC  = LIN_SHORT_US * CLK_MHZ;
  localparam int unsigned AUX_SHORT_CYC  = AUX_SHORT_US * CLK_MHZ;
  localparam int unsigned WAKE_SHORT_CYC = WAKE_SHORT_US * CLK_MHZ;
  localparam int unsigned WAKE_TO_CYC    = WAKE_TO_MS * CLK_MHZ * 1000;

  // ------------------------------------------------------------------
  // channels: index equals short flag position in the monitor
  // ------------------------------------------------------------------
  localparam int unsigned CH_WAKE = 0;
  localparam int unsigned CH_AUX  = 1;
  localparam int unsigned CH_LIN  = 2;
  localparam int unsigned NCH     = 3;
  localparam int unsigned SH_THRM = 3;

  // ------------------------------------------------------------------
  // hv_config_one fields
  // ------------------------------------------------------------------
  localparam int unsigned CFG_PULLUP  = 0;
  localparam int unsigned CFG_TO_DIS  = 1;
  localparam int unsigned CFG_PASSIVE = 2;
  localparam int unsigned CFG_REEN    = 3;
  localparam int unsigned CFG_RDBK    = 4;

  // ------------------------------------------------------------------
  // indirect commands and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] CMD_RD_MON  = 8'h01;
  localparam logic [7:0] CMD_RD_CFG1 = 8'h02;
  localparam logic [7:0] CMD_WR_CFG1 = 8'h03;
  localparam logic [7:0] MON_RST     = 8'h00;
  localparam logic [7:0] CFG1_RST    = 8'h00;

  // synchronised pin-side inputs
  typedef struct packed {
    logic       lowv;
    logic       buf_en;
    logic       aux_lvl;
    logic       wake_lvl;
  } hvp_rdbk_s;

  typedef struct packed {
    logic [7:0]             cfg;
    logic                   reen;
    logic [NCH-1:0]         drv_en;
    logic [NCH-1:0]         sc_flag;
    logic                   ovt;
    logic                   pend;
    logic [7:0]             mon;
    logic [7:0]             dat;
    logic [3:0]             sh_s1;
    logic [3:0]             sh_s2;
    hvp_rdbk_s              rb_s1;
    hvp_rdbk_s              rb_s2;
    logic [31:0]            to_cnt;
    logic                   to_done;
    logic [NCH-1:0][31:0]   sc_cnt;
  } hvp_state_s;

  localparam hvp_state_s ST_RST = '{drv_en: 3'h7, cfg: CFG1_RST,
                                    mon: MON_RST, default: '0};

endpackage

// *** rtl/hvp_protect.sv ***
// module: short-circuit protection, wake timeout and monitor for hv pins
`timescale 1ns/1ps
// Notes on behaviour
// - writing re-enable restores pins disabled by shorts (20 us, 400 us wake)
// - after a thermal disable, re-enable restores wake and aux pins
// - short interrupt stays pending until software writes re-enable
// - re-enable bit clears itself one cycle after the write
// - passive mode: short flags and interrupts, lin and aux drivers stay enabled (wake still disables)
// - active mode: short flags, interrupts, disables pin until re-enable
// - interrupt line only reaches processor with enable bit 16 set
// - wake drive drops 1.3 s after assert unless timeout disabled
// - open-circuit bit connects wake pull-up; clearing removes it
// - monitor is 8 bits, read-only, resets to zero, shows live state
// - monitor read only via indirect command then indirect data
// - monitor bit 2 lin short, bit 1 aux short, cleared by re-enable
module hvp_protect #(
  parameter int unsigned WAKE_SHORT_CYC = hvp_pkg::WAKE_SHORT_CYC,
  parameter int unsigned WAKE_TO_CYC    = hvp_pkg::WAKE_TO_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cmd_wr,
  input  wire logic [7:0] cmd_code,
  input  wire logic       dat_wr,
  input  wire logic [7:0] dat_wdata,
  output logic      [7:0] hv_indirect_data,
  input  wire logic       irq_en_hv,
  output logic            hv_irq_line,
  input  wire logic       wake_req,
  input  wire logic       lin_short_raw,
  input  wire logic       aux_short_raw,
  input  wire logic       wake_short_raw,
  input  wire logic       thermal_raw,
  input  wire logic       wake_pin_lvl,
  input  wire logic       aux_pin_lvl,
  input  wire logic       buf_en_raw,
  input  wire logic       lowv_raw,
  output logic            lin_drv_en,
  output logic            aux_drv_en,
  output logic            wake_drv_en,
  output logic            wake_drive,
  output logic            wake_pullup_en,
  output logic      [7:0] hv_config_one
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  hvp_pkg::hvp_state_s st_q;
  hvp_pkg::hvp_state_s st_d;
  logic [hvp_pkg::NCH-1:0]       det;
  logic [hvp_pkg::NCH-1:0][31:0] lim;
  logic                          passive;

  // per-channel persistence limits; wake needs a much longer short
  assign lim[hvp_pkg::CH_WAKE] = 32'(WAKE_SHORT_CYC);
  assign lim[hvp_pkg::CH_AUX]  = 32'(hvp_pkg::AUX_SHORT_CYC);
  assign lim[hvp_pkg::CH_LIN]  = 32'(hvp_pkg::LIN_SHORT_CYC);
  assign passive = st_q.cfg[hvp_pkg::CFG_PASSIVE];

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    det  = '0;
    // two-flop synchronisers; stage one feeds only stage two
    st_d.sh_s1 = {thermal_raw, lin_short_raw, aux_short_raw,
                  wake_short_raw};
    st_d.sh_s2 = st_q.sh_s1;
    st_d.rb_s1 = '{lowv: lowv_raw, buf_en: buf_en_raw,
                   aux_lvl: aux_pin_lvl, wake_lvl: wake_pin_lvl};
    st_d.rb_s2 = st_q.rb_s1;

    st_d.reen = 1'b0;

    // indirect access; a command beats a data write in the same cycle
    // monitor only reachable through command plus data register
    if (cmd_wr) begin
      unique case (cmd_code)
        hvp_pkg::CMD_RD_MON:  st_d.dat = st_q.mon;
        hvp_pkg::CMD_RD_CFG1: st_d.dat = st_q.cfg;
        hvp_pkg::CMD_WR_CFG1: begin
          st_d.cfg = st_q.dat;
          st_d.cfg[hvp_pkg::CFG_REEN] = 1'b0;
          // a zero here leaves pins, flags and pending alone
          st_d.reen = st_q.dat[hvp_pkg::CFG_REEN];
        end
        // unknown codes leave the data register alone
        default: st_d.dat = st_q.dat;
      endcase
    end else if (dat_wr) begin
      st_d.dat = dat_wdata;
    end

    // thermal disables cleared the same way
    if (st_q.reen) begin
      st_d.drv_en  = '1;
      st_d.sc_flag = '0;
      st_d.ovt     = 1'b0;
      st_d.pend    = 1'b0;
    end

    // persistence counters; detection set wins over a same-cycle clear
    // the count parks at its limit, so one short gives one detection
    for (int i = 0; i < hvp_pkg::NCH; i++) begin
      if (!st_q.sh_s2[i]) begin
        st_d.sc_cnt[i] = '0;
      end else if (st_q.sc_cnt[i] != lim[i]) begin
        st_d.sc_cnt[i] = st_q.sc_cnt[i] + 32'h1;
        det[i] = (st_q.sc_cnt[i] == lim[i] - 32'h1);
      end
      if (det[i]) begin
        st_d.sc_flag[i] = 1'b1;
        st_d.pend = 1'b1;
        // passive lin/aux keep driver; wake always disables
        // active mode disables the shorted driver
        if (i == hvp_pkg::CH_WAKE || !passive) begin
          st_d.drv_en[i] = 1'b0;
        end
      end
    end

    // thermal shutdown holds wake and aux off until a re-enable after it ends
    // heat raises no pending interrupt; only shorts do
    if (st_q.sh_s2[hvp_pkg::SH_THRM]) begin
      st_d.ovt = 1'b1;
      st_d.drv_en[hvp_pkg::CH_WAKE] = 1'b0;
      st_d.drv_en[hvp_pkg::CH_AUX]  = 1'b0;
    end

    // wake timeout; counter frozen while timeout is disabled
    // limitation: a disable set mid-count only pauses the count
    if (!wake_req) begin
      st_d.to_cnt  = '0;
      st_d.to_done = 1'b0;
    end else if (!st_q.to_done && !st_q.cfg[hvp_pkg::CFG_TO_DIS]) begin
      st_d.to_cnt  = st_q.to_cnt + 32'h1;
      st_d.to_done = (st_q.to_cnt == 32'(WAKE_TO_CYC) - 32'h1);
    end

    // live monitor snapshot, wake and aux pin levels gated by cfg bit 4
    // lags the flags by one cycle, so a read never sees half an update
    st_d.mon = {st_q.rb_s2.wake_lvl & st_q.cfg[hvp_pkg::CFG_RDBK],
                st_q.ovt,
                st_q.rb_s2.aux_lvl & st_q.cfg[hvp_pkg::CFG_RDBK],
                st_q.rb_s2.buf_en,
                st_q.rb_s2.lowv,
                st_q.sc_flag};
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  // synchronous reset to the package reset image
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= hvp_pkg::ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // interrupt gated by enable bit 16
  assign hv_irq_line      = st_q.pend & irq_en_hv;
  // driver enables straight from flops, so the pins never glitch
  assign lin_drv_en       = st_q.drv_en[hvp_pkg::CH_LIN];
  assign aux_drv_en       = st_q.drv_en[hvp_pkg::CH_AUX];
  assign wake_drv_en      = st_q.drv_en[hvp_pkg::CH_WAKE];
  // wake drive also needs the driver alive; timeout is the monoflop
  assign wake_drive       = wake_req & ~st_q.to_done &
                            st_q.drv_en[hvp_pkg::CH_WAKE];
  // pull-up follows the open-circuit diagnostic bit
  assign wake_pullup_en   = st_q.cfg[hvp_pkg::CFG_PULLUP];
  assign hv_indirect_data = st_q.dat;
  assign hv_config_one    = st_q.cfg;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  // all checks live in the clk domain and pause while in reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_reen_selfclear: assert property (
    cmd_wr && cmd_code == hvp_pkg::CMD_WR_CFG1 &&
    st_q.dat[hvp_pkg::CFG_REEN] |=> st_q.reen ##1
    (!st_q.reen || $past(cmd_wr && cmd_code == hvp_pkg::CMD_WR_CFG1 &&
                         st_q.dat[hvp_pkg::CFG_REEN])))
    else $error("re-enable did not pulse for exactly one cycle");

  chk_reen_restore: assert property (
    st_q.reen && det == '0 && !st_q.sh_s2[hvp_pkg::SH_THRM]
    |=> st_q.drv_en == '1 && st_q.sc_flag == '0)
    else $error("re-enable did not restore drivers");

  chk_thermal_off: assert property (
    st_q.sh_s2[hvp_pkg::SH_THRM] |=> !wake_drv_en && !aux_drv_en &&
    st_q.ovt)
    else $error("thermal event did not disable wake and aux");

  chk_pend_sticky: assert property (
    st_q.pend && !st_q.reen |=> st_q.pend [*1] ##0 $stable(st_q.pend))
    else $error("pending interrupt dropped without re-enable");

  chk_passive_lin: assert property (
    passive && det[hvp_pkg::CH_LIN] && lin_drv_en
    |=> lin_drv_en && st_q.pend && st_q.sc_flag[hvp_pkg::CH_LIN])
    else $error("passive mode short handled wrongly");

  chk_active_lin: assert property (
    !passive && det[hvp_pkg::CH_LIN]
    |=> !lin_drv_en && st_q.pend && st_q.sc_flag[hvp_pkg::CH_LIN])
    else $error("active mode short did not disable lin");

  chk_irq_gate: assert property (
    hv_irq_line |-> irq_en_hv && st_q.pend)
    else $error("interrupt seen without enable");

  chk_wake_hold: assert property (
    wake_req && st_q.cfg[hvp_pkg::CFG_TO_DIS] && wake_drv_en &&
    !st_q.to_done |=> (wake_req && wake_drv_en) |-> wake_drive)
    else $error("wake dropped with timeout disabled");

  chk_pullup_follow: assert property (
    cmd_wr && cmd_code == hvp_pkg::CMD_WR_CFG1
    |=> wake_pullup_en == $past(st_q.dat[hvp_pkg::CFG_PULLUP]))
    else $error("pull-up did not follow diagnostic bit");

  chk_mon_read: assert property (
    cmd_wr && cmd_code == hvp_pkg::CMD_RD_MON
    |=> hv_indirect_data == $past(st_q.mon))
    else $error("monitor read returned wrong value");

  chk_flag_clear: assert property (
    st_q.reen && !det[hvp_pkg::CH_LIN] && !det[hvp_pkg::CH_AUX]
    |=> !st_q.sc_flag[hvp_pkg::CH_LIN] && !st_q.sc_flag[hvp_pkg::CH_AUX])
    else $error("short flags survived re-enable");

  chk_zero_noop: assert property (
    cmd_wr && cmd_code == hvp_pkg::CMD_WR_CFG1 &&
    !st_q.dat[hvp_pkg::CFG_REEN] && !st_q.reen && st_q.pend
    |=> ##1 st_q.pend)
    else $error("zero re-enable write cleared pending");

  // pending comes only from a short detection, never from heat
  chk_pend_source: assert property (
    $rose(st_q.pend) |-> $past(det) != '0)
    else $error("pending interrupt rose without a short");

  // a lin short flag stands until re-enable
  chk_flag_hold: assert property (
    st_q.sc_flag[hvp_pkg::CH_LIN] && !st_q.reen
    |=> st_q.sc_flag[hvp_pkg::CH_LIN])
    else $error("lin short flag dropped without re-enable");

  // the monoflop cuts the drive on the cycle after the count ends
  chk_wake_timeout: assert property (
    wake_req && !st_q.cfg[hvp_pkg::CFG_TO_DIS] && !st_q.to_done &&
    st_q.to_cnt == 32'(WAKE_TO_CYC) - 32'h1
    |=> !wake_drive || !wake_req)
    else $error("wake drive outlived its timeout");

  // the re-enable bit never reads back as one
  chk_reen_reads_zero: assert property (
    !hv_config_one[hvp_pkg::CFG_REEN])
    else $error("re-enable bit read back as one");

  // a wake short drops the wake driver in either mode
  chk_wake_short: assert property (
    det[hvp_pkg::CH_WAKE] |=> !wake_drv_en &&
    st_q.sc_flag[hvp_pkg::CH_WAKE])
    else $error("wake short did not disable wake driver");

  // passive mode keeps the aux driver alive but still flags
  chk_passive_aux: assert property (
    passive && det[hvp_pkg::CH_AUX] && aux_drv_en &&
    !st_q.sh_s2[hvp_pkg::SH_THRM]
    |=> aux_drv_en && st_q.pend)
    else $error("passive aux short handled wrongly");

  // first cycle out of reset shows the reset image
  chk_reset_image: assert property (
    $fell(rst) |-> st_q.mon == hvp_pkg::MON_RST &&
    hv_config_one == hvp_pkg::CFG1_RST && st_q.drv_en == '1 &&
    !st_q.pend)
    else $error("state after reset differs from reset image");

  // overtemperature and its disables stand until re-enable
  chk_thermal_hold: assert property (
    st_q.ovt && !st_q.reen
    |=> st_q.ovt && !wake_drv_en && !aux_drv_en)
    else $error("thermal disable released without re-enable");

endmodule

// *** verification/hvp_pin_model.sv ***
// partner model: external hv lines, fault detectors and pin levels
`timescale 1ns/1ps
module hvp_pin_model (
  input  wire logic clk,
  input  wire logic lin_fault,
  input  wire logic aux_fault,
  input  wire logic wake_fault,
  input  wire logic hot,
  input  wire logic wake_drive,
  input  wire logic wake_pullup_en,
  output logic      lin_short_raw,
  output logic      aux_short_raw,
  output logic      wake_short_raw,
  output logic      thermal_raw,
  output logic      wake_pin_lvl,
  output logic      aux_pin_lvl
);
  // ----------------------------------------------------------------
  // detector outputs
  // ----------------------------------------------------------------
  // detectors settle just after an edge, never on it
  always_ff @(posedge clk) begin
    lin_short_raw  <= lin_fault;
    aux_short_raw  <= aux_fault;
    wake_short_raw <= wake_fault;
    thermal_raw    <= hot;
  end
  // pulled-up open line
  // an unconnected wake line rises only while driven or pulled up
  assign wake_pin_lvl = wake_drive | wake_pullup_en;
  assign aux_pin_lvl  = ~aux_fault; // shorted aux line sits low
endmodule

// *** verification/hv_io_protection_control_tb.sv ***
// testbench: short protection, wake timeout and monitor scenarios
`timescale 1ns/1ps
module hv_io_protection_control_tb;
  logic       clk, rst, cmd_wr, dat_wr, irq_en_hv, wake_req;
  logic       buf_en_raw, lowv_raw, lin_f, aux_f, wake_f, hot;
  logic       lin_s, aux_s, wake_s, therm, wake_lvl, aux_lvl;
  logic       hv_irq_line, lin_drv_en, aux_drv_en, wake_drv_en;
  logic       wake_drive, wake_pullup_en;
  logic [7:0] cmd_code, dat_wdata, hv_indirect_data, hv_config_one, drv;
  int         n_mismatch, total_checks;

  // wake short and wake timeout counts kept small so the run stays brief
  hvp_protect #(.WAKE_SHORT_CYC(40), .WAKE_TO_CYC(50)) uut (
    .clk(clk), .rst(rst), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
    .dat_wr(dat_wr), .dat_wdata(dat_wdata),
    .hv_indirect_data(hv_indirect_data), .irq_en_hv(irq_en_hv),
    .hv_irq_line(hv_irq_line), .wake_req(wake_req),
    .lin_short_raw(lin_s), .aux_short_raw(aux_s),
    .wake_short_raw(wake_s), .thermal_raw(therm),
    .wake_pin_lvl(wake_lvl), .aux_pin_lvl(aux_lvl),
    .buf_en_raw(buf_en_raw), .lowv_raw(lowv_raw),
    .lin_drv_en(lin_drv_en), .aux_drv_en(aux_drv_en),
    .wake_drv_en(wake_drv_en), .wake_drive(wake_drive),
    .wake_pullup_en(wake_pullup_en), .hv_config_one(hv_config_one));
  hvp_pin_model pins (
    .clk(clk), .lin_fault(lin_f), .aux_fault(aux_f), .wake_fault(wake_f),
    .hot(hot), .wake_drive(wake_drive), .wake_pullup_en(wake_pullup_en),
    .lin_short_raw(lin_s), .aux_short_raw(aux_s), .wake_short_raw(wake_s),
    .thermal_raw(therm), .wake_pin_lvl(wake_lvl), .aux_pin_lvl(aux_lvl));
  assign drv = {5'h00, lin_drv_en, aux_drv_en, wake_drv_en};

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // sampling on the falling edge keeps clear of launch races
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // data first, then the write command a cycle later
  task automatic wr_cfg(input logic [7:0] v);
    @(posedge clk) begin
      dat_wr    <= 1'b1;
      dat_wdata <= v;
    end
    @(posedge clk) begin
      dat_wr   <= 1'b0;
      cmd_wr   <= 1'b1;
      cmd_code <= 8'h03;
    end
    @(posedge clk) cmd_wr <= 1'b0;
    cyc(4);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    @(posedge clk) begin
      cmd_wr   <= 1'b1;
      cmd_code <= c;
    end
    @(posedge clk) cmd_wr <= 1'b0;
    cyc(2);
    chk(hv_indirect_data, exp);
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_lin_active;
    @(posedge clk) lin_f <= 1'b1;
    cyc(2600);
    chk(drv, 8'h03);
    chk({7'h0, hv_irq_line}, 8'h00);
    @(posedge clk) irq_en_hv <= 1'b1;
    @(posedge clk) lin_f <= 1'b0;
    cyc(40);
    chk({7'h0, hv_irq_line}, 8'h01);
    rd(8'h01, 8'h04);
    wr_cfg(8'h00);
    chk(drv, 8'h03);
    chk({7'h0, hv_irq_line}, 8'h01);
    wr_cfg(8'h08);
    chk(hv_config_one, 8'h00);
    chk(drv, 8'h07);
    chk({7'h0, hv_irq_line}, 8'h00);
    rd(8'h01, 8'h00);
  endtask
  task automatic t_aux_passive;
    wr_cfg(8'h04);
    @(posedge clk) {lin_f, aux_f} <= 2'h3;
    cyc(2600);
    chk(drv, 8'h07);
    chk({7'h0, hv_irq_line}, 8'h01);
    @(posedge clk) {lin_f, aux_f} <= 2'h0;
    rd(8'h01, 8'h06);
    wr_cfg(8'h0c);
    chk(hv_config_one, 8'h04);
    rd(8'h02, 8'h04);
    rd(8'h7e, 8'h04);
    rd(8'h01, 8'h00);
    wr_cfg(8'h00);
  endtask
  task automatic t_thermal_wake;
    @(posedge clk) hot <= 1'b1;
    cyc(10);
    @(posedge clk) hot <= 1'b0;
    cyc(6);
    chk(drv, 8'h04);
    rd(8'h01, 8'h40);
    wr_cfg(8'h08);
    chk(drv, 8'h07);
    @(posedge clk) wake_f <= 1'b1;
    cyc(60);
    @(posedge clk) wake_f <= 1'b0;
    cyc(1);
    chk(drv, 8'h06);
    rd(8'h01, 8'h01);
    wr_cfg(8'h08);
    chk(drv, 8'h07);
  endtask
  task automatic t_timeout_pullup;
    @(posedge clk) wake_req <= 1'b1;
    cyc(5);
    chk({7'h0, wake_drive}, 8'h01);
    cyc(60);
    chk({7'h0, wake_drive}, 8'h00);
    @(posedge clk) wake_req <= 1'b0;
    wr_cfg(8'h02);
    @(posedge clk) wake_req <= 1'b1;
    cyc(80);
    chk({7'h0, wake_drive}, 8'h01);
    @(posedge clk) wake_req <= 1'b0;
    wr_cfg(8'h11);
    chk({7'h0, wake_pullup_en}, 8'h01);
    rd(8'h01, 8'ha0);
    wr_cfg(8'h00);
    chk({7'h0, wake_pullup_en}, 8'h00);
  endtask
  // reset in mid-run with a flag, config and live levels standing
  task automatic t_reset_mid;
    wr_cfg(8'h15);
    @(posedge clk) {wake_f, buf_en_raw, lowv_raw} <= 3'h7;
    cyc(60);
    chk(drv, 8'h06);
    rd(8'h01, 8'hb9);
    @(posedge clk) begin
      wake_f <= 1'b0;
      rst    <= 1'b1;
    end
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk(drv, 8'h07);
    chk({7'h0, hv_irq_line}, 8'h00);
    chk(hv_config_one, 8'h00);
    cyc(4);
    rd(8'h01, 8'h18);
    @(posedge clk) {buf_en_raw, lowv_raw} <= 2'h0;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // the whole run needs under 8000 cycles
  initial begin
    #240000;
    n_mismatch++;
    summarize();
  end
  initial begin
    {rst, cmd_wr, dat_wr, irq_en_hv, wake_req} = 5'h10;
    {buf_en_raw, lowv_raw, lin_f, aux_f, wake_f, hot} = 6'h00;
    cmd_code = 8'h00;
    dat_wdata = 8'h00;
    n_mismatch = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    cyc(4);
    chk(drv, 8'h07);
    rd(8'h01, 8'h00);
    t_lin_active();
    t_aux_passive();
    t_thermal_wake();
    t_timeout_pullup();
    t_reset_mid();
    summarize();
  end
endmodule
